// >>> dgp_top.sv
// dual 8-bit gpio port with peripheral pin mux and axi4-lite registers
`timescale 1ns/1ns
// What this block does
// - direction bit one tri-states the pin driver, pin becomes input
// - direction bit zero drives the pin from its output latch
// - output latch is addressable and reads back latch, not pin
// - two eight-bit ports, every pin individually input or output
// - every reset sets all direction bits to one, pins inputs
// - enabled peripherals override direction, forcing output or input
// - direction register reads stored bits even while overridden
// - port c bits 3,4,5 feed external interrupts 0,1,2
// - serial select moves serial pins from c4,c5,c7 to d2,d3,d1
// - serial port receive/data on c7, transmit/clock on c6
// - timer0/timer5 clock from c3, or d0 when select is one
// - faults a,b on c1,c2; fault a select moves a to d4
// - port d bits 6,7 carry fourth complementary pwm pair
// - config bit puts third channel complement on d5
// - c1 serves capture unit 2 only while its select is clear
// - c2 serves capture unit 1 input or output
// - c0 timer1 osc output/clock input, c1 timer1 osc input
// - c6 is spi slave select input in spi slave mode
// - port d and its registers are optional by parameter
module dgp_top
    import dgp_pkg::*;
#(
    parameter bit HAS_PORT_D = 1'b1
)(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [DGP_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [DGP_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [7:0]        port_c_in,
    output logic [7:0]             port_c_out,
    output logic [7:0]             port_c_oe_n,
    input  wire logic [7:0]        port_d_in,
    output logic [7:0]             port_d_out,
    output logic [7:0]             port_d_oe_n,
    input  wire dgp_drv_t          timer1_osc_output,
    input  wire dgp_drv_t          capture_compare_unit1,
    input  wire dgp_drv_t          capture_compare_unit2,
    input  wire dgp_drv_t          ssp_data_out,
    input  wire dgp_drv_t          ssp_clock_out,
    input  wire dgp_drv_t          ssp_sda_out,
    input  wire dgp_drv_t          usart_tx_clock,
    input  wire dgp_drv_t          usart_data_out,
    input  wire dgp_drv_t          pwm_out_4,
    input  wire dgp_drv_t          pwm_out_6,
    input  wire dgp_drv_t          pwm_out_7,
    input  wire logic              timer1_osc_enable,
    input  wire logic              spi_slave_mode,
    output logic                   external_irq_0,
    output logic                   external_irq_1,
    output logic                   external_irq_2,
    output logic                   timer0_ext_clock,
    output logic                   timer5_ext_clock,
    output logic                   fault_input_a,
    output logic                   fault_input_b,
    output logic                   timer1_ext_clock,
    output logic                   timer1_osc_input,
    output logic                   capture_compare_unit1_capture_in,
    output logic                   capture_compare_unit2_capture_in,
    output logic                   ssp_data_in,
    output logic                   ssp_clock_in,
    output logic                   spi_slave_select_n,
    output logic                   usart_rx_data
);

    logic [7:0] c_dir_q;
    logic [7:0] d_dir_q;
    logic [7:0] c_lat_q;
    logic [7:0] d_lat_q;
    logic [7:0] c_pin_q;
    logic [7:0] d_pin_q;
    dgp_cfg_t   cfg_q;
    logic [7:0] c_drv;
    logic [7:0] c_val;
    logic [7:0] d_drv;
    logic [7:0] d_val;
    logic       wr_go;
    logic       rd_go;
    logic       bvalid_q;
    logic [1:0] bresp_q;
    logic       rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [7:0] rd_byte;
    logic       rd_hit;
    logic       wr_hit;
    logic       d_addr;

    // both write channels are taken together, one write outstanding
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign rd_go         = s_axi_arvalid && !rvalid_q;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // port d addresses decode only when the second port exists
    always_comb
    begin
        d_addr = (s_axi_awaddr == DGP_D_PIN_OFF) || (s_axi_awaddr == DGP_D_LAT_OFF)
              || (s_axi_awaddr == DGP_D_DIR_OFF);
        wr_hit = (s_axi_awaddr == DGP_C_PIN_OFF) || (s_axi_awaddr == DGP_C_LAT_OFF)
              || (s_axi_awaddr == DGP_C_DIR_OFF) || (s_axi_awaddr == DGP_CFG_OFF)
              || (d_addr && HAS_PORT_D);
    end

    // direction registers: all ones on every reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            c_dir_q <= DGP_DIR_RST;
            d_dir_q <= DGP_DIR_RST;
        end
        else if (wr_go && s_axi_wstrb[0])
        begin
            if (s_axi_awaddr == DGP_C_DIR_OFF)
                c_dir_q <= s_axi_wdata[7:0];
            if (s_axi_awaddr == DGP_D_DIR_OFF && HAS_PORT_D)
                d_dir_q <= s_axi_wdata[7:0];
        end
    end

    // latches carry no reset so they survive warm resets
    always_ff @(posedge aclk)
    begin
        if (wr_go && s_axi_wstrb[0])
        begin
            if (s_axi_awaddr == DGP_C_LAT_OFF || s_axi_awaddr == DGP_C_PIN_OFF)
                c_lat_q <= s_axi_wdata[7:0];
            if ((s_axi_awaddr == DGP_D_LAT_OFF || s_axi_awaddr == DGP_D_PIN_OFF) && HAS_PORT_D)
                d_lat_q <= s_axi_wdata[7:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cfg_q <= dgp_cfg_t'(DGP_CFG_RST);
        else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == DGP_CFG_OFF)
            cfg_q <= dgp_cfg_t'(s_axi_wdata[4:0]);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= DGP_RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? DGP_RESP_OKAY : DGP_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    // read mux: pin register shows sampled levels, latch shows latch
    always_comb
    begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            DGP_C_PIN_OFF: rd_byte = c_pin_q;
            DGP_C_LAT_OFF: rd_byte = c_lat_q;
            DGP_C_DIR_OFF: rd_byte = c_dir_q;
            DGP_D_PIN_OFF: rd_byte = d_pin_q;
            DGP_D_LAT_OFF: rd_byte = d_lat_q;
            DGP_D_DIR_OFF: rd_byte = d_dir_q;
            DGP_CFG_OFF:   rd_byte = {3'h0, cfg_q};
            default:       rd_hit  = 1'b0;
        endcase
        if (!HAS_PORT_D && (s_axi_araddr == DGP_D_PIN_OFF || s_axi_araddr == DGP_D_LAT_OFF
                            || s_axi_araddr == DGP_D_DIR_OFF))
        begin
            rd_byte = 8'h00;
            rd_hit  = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rresp_q  <= DGP_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end
        else if (rd_go)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_hit ? DGP_RESP_OKAY : DGP_RESP_SLVERR;
            rdata_q  <= {24'h00_0000, rd_byte};
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // pin sampling; absent port d reads as zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            c_pin_q <= 8'h00;
        else
            c_pin_q <= port_c_in;
    end

    generate
        if (HAS_PORT_D)
        begin : g_port_d
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    d_pin_q <= 8'h00;
                else
                    d_pin_q <= port_d_in;
            end
        end
        else
        begin : g_no_port_d
            assign d_pin_q = 8'h00;
        end
    endgenerate

    // port c driver mux: default from direction and latch, then peripherals
    always_comb
    begin
        c_drv = ~c_dir_q;
        c_val = c_lat_q;
        if (timer1_osc_output.en)
        begin
            c_drv[0] = 1'b1;
            c_val[0] = timer1_osc_output.val;
        end
        if (timer1_osc_enable)
            c_drv[1] = 1'b0;
        else if (capture_compare_unit2.en && !cfg_q.capture_unit2_pin_select)
        begin
            c_drv[1] = 1'b1;
            c_val[1] = capture_compare_unit2.val;
        end
        if (capture_compare_unit1.en)
        begin
            c_drv[2] = 1'b1;
            c_val[2] = capture_compare_unit1.val;
        end
        if (ssp_sda_out.en && !cfg_q.serial_port_pin_select)
        begin
            c_drv[4] = 1'b1;
            c_val[4] = ssp_sda_out.val;
        end
        if (ssp_clock_out.en && !cfg_q.serial_port_pin_select)
        begin
            c_drv[5] = 1'b1;
            c_val[5] = ssp_clock_out.val;
        end
        if (spi_slave_mode)
            c_drv[6] = 1'b0;
        else if (usart_tx_clock.en)
        begin
            c_drv[6] = 1'b1;
            c_val[6] = usart_tx_clock.val;
        end
        if (usart_data_out.en)
        begin
            c_drv[7] = 1'b1;
            c_val[7] = usart_data_out.val;
        end
        else if (ssp_data_out.en && !cfg_q.serial_port_pin_select)
        begin
            c_drv[7] = 1'b1;
            c_val[7] = ssp_data_out.val;
        end
    end

    // port d driver mux
    always_comb
    begin
        d_drv = ~d_dir_q;
        d_val = d_lat_q;
        if (cfg_q.serial_port_pin_select)
        begin
            if (ssp_data_out.en)
            begin
                d_drv[1] = 1'b1;
                d_val[1] = ssp_data_out.val;
            end
            if (ssp_sda_out.en)
            begin
                d_drv[2] = 1'b1;
                d_val[2] = ssp_sda_out.val;
            end
            if (ssp_clock_out.en)
            begin
                d_drv[3] = 1'b1;
                d_val[3] = ssp_clock_out.val;
            end
        end
        if (pwm_out_4.en && cfg_q.alt_complement_output_select)
        begin
            d_drv[5] = 1'b1;
            d_val[5] = pwm_out_4.val;
        end
        if (pwm_out_6.en)
        begin
            d_drv[6] = 1'b1;
            d_val[6] = pwm_out_6.val;
        end
        if (pwm_out_7.en)
        begin
            d_drv[7] = 1'b1;
            d_val[7] = pwm_out_7.val;
        end
        if (!HAS_PORT_D)
            d_drv = 8'h00;
    end

    // registered pin drive; value masked to zero on every pin the block does not drive
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_c_oe_n <= 8'hff;
            port_c_out  <= 8'h00;
            port_d_oe_n <= 8'hff;
            port_d_out  <= 8'h00;
        end
        else
        begin
            port_c_oe_n <= ~c_drv;
            port_c_out  <= c_val & c_drv;
            port_d_oe_n <= ~d_drv;
            port_d_out  <= d_val & d_drv;
        end
    end

    // inputs to peripherals, taken from the sampled pins
    always_comb
    begin
        external_irq_0     = c_pin_q[3];
        external_irq_1     = c_pin_q[4];
        external_irq_2     = c_pin_q[5];
        timer0_ext_clock   = cfg_q.ext_clock_pin_select ? d_pin_q[0] : c_pin_q[3];
        timer5_ext_clock   = timer0_ext_clock;
        fault_input_a      = cfg_q.fault_a_pin_select ? d_pin_q[4] : c_pin_q[1];
        fault_input_b      = c_pin_q[2];
        timer1_ext_clock   = c_pin_q[0];
        timer1_osc_input   = c_pin_q[1];
        capture_compare_unit1_capture_in    = c_pin_q[2];
        capture_compare_unit2_capture_in    = cfg_q.capture_unit2_pin_select ? 1'b0 : c_pin_q[1];
        ssp_data_in        = cfg_q.serial_port_pin_select ? d_pin_q[2] : c_pin_q[4];
        ssp_clock_in       = cfg_q.serial_port_pin_select ? d_pin_q[3] : c_pin_q[5];
        spi_slave_select_n = c_pin_q[6];
        usart_rx_data      = c_pin_q[7];
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_c_input;
        c_dir_q == 8'hff && !timer1_osc_output.en && !capture_compare_unit1.en
            && !capture_compare_unit2.en && !usart_tx_clock.en && !usart_data_out.en
            && !ssp_data_out.en && !ssp_sda_out.en && !ssp_clock_out.en
            |=> port_c_oe_n == 8'hff;
    endproperty
    a_c_input: assert property (p_c_input) else $error("input direction still driven");

    property p_c_drive;
        c_dir_q[3] == 1'b0 |=> !port_c_oe_n[3] && port_c_out[3] == $past(c_lat_q[3]);
    endproperty
    a_c_drive: assert property (p_c_drive) else $error("output pin not showing latch");

    property p_lat_read;
        rd_go && s_axi_araddr == DGP_C_LAT_OFF |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(c_lat_q);
    endproperty
    a_lat_read: assert property (p_lat_read) else $error("latch read wrong");

    property p_reset_dir;
        disable iff (1'b0) !aresetn |=> c_dir_q == 8'hff && d_dir_q == 8'hff && port_c_oe_n == 8'hff;
    endproperty
    a_reset_dir: assert property (p_reset_dir) else $error("direction not set by reset");

    property p_override;
        usart_tx_clock.en && !spi_slave_mode |=> !port_c_oe_n[6] && port_c_out[6] == $past(usart_tx_clock.val);
    endproperty
    a_override: assert property (p_override) else $error("peripheral override lost");

    property p_dir_read;
        rd_go && s_axi_araddr == DGP_C_DIR_OFF |=> s_axi_rdata[7:0] == $past(c_dir_q) ##1 1;
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction read wrong");

    property p_irq;
        1'b1 |=> external_irq_0 == $past(port_c_in[3]) && external_irq_2 == $past(port_c_in[5]);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt input misrouted");

    property p_serial;
        cfg_q.serial_port_pin_select && HAS_PORT_D
            |-> ssp_data_in == $past(port_d_in[2]) && ssp_clock_in == $past(port_d_in[3]);
    endproperty
    a_serial: assert property (p_serial) else $error("serial pins misrouted");

    property p_tmr_clk;
        $past(aresetn) && !cfg_q.ext_clock_pin_select
            |-> timer0_ext_clock == $past(port_c_in[3]) && timer5_ext_clock == $past(port_c_in[3]);
    endproperty
    a_tmr_clk: assert property (p_tmr_clk) else $error("timer clock misrouted");

    property p_fault_a;
        cfg_q.fault_a_pin_select && HAS_PORT_D |-> fault_input_a == $past(port_d_in[4]);
    endproperty
    a_fault_a: assert property (p_fault_a) else $error("fault a misrouted");

    property p_pwm;
        pwm_out_7.en && HAS_PORT_D |=> !port_d_oe_n[7] && port_d_out[7] == $past(pwm_out_7.val);
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm pair not driven");

    property p_bresp;
        wr_go |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write not answered");

    c_write: cover property (wr_go && s_axi_awaddr == DGP_C_LAT_OFF);
    c_read:  cover property (rd_go && s_axi_araddr == DGP_C_PIN_OFF);
    c_swap:  cover property (cfg_q.serial_port_pin_select && ssp_data_out.en);

endmodule // dgp_top

// >>> dgp_pkg.sv
// package: register map, config layout and bus codes for the dual gpio port
package dgp_pkg;
    localparam int          DGP_AW          = 8;
    localparam logic [7:0]  DGP_C_PIN_OFF   = 8'h00;
    localparam logic [7:0]  DGP_C_LAT_OFF   = 8'h04;
    localparam logic [7:0]  DGP_C_DIR_OFF   = 8'h08;
    localparam logic [7:0]  DGP_D_PIN_OFF   = 8'h0c;
    localparam logic [7:0]  DGP_D_LAT_OFF   = 8'h10;
    localparam logic [7:0]  DGP_D_DIR_OFF   = 8'h14;
    localparam logic [7:0]  DGP_CFG_OFF     = 8'h18;
    localparam logic [7:0]  DGP_DIR_RST     = 8'hff;
    localparam logic [4:0]  DGP_CFG_RST     = 5'h00;
    localparam logic [1:0]  DGP_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  DGP_RESP_SLVERR = 2'h2;
    // config bit positions inside the config register
    localparam int          DGP_CFG_CAPTURE_COMPARE_UNIT2    = 0;
    localparam int          DGP_CFG_SERIAL  = 1;
    localparam int          DGP_CFG_EXTCLK  = 2;
    localparam int          DGP_CFG_FAULTA  = 3;
    localparam int          DGP_CFG_ALTCMP  = 4;

    typedef struct packed {
        logic alt_complement_output_select;
        logic fault_a_pin_select;
        logic ext_clock_pin_select;
        logic serial_port_pin_select;
        logic capture_unit2_pin_select;
    } dgp_cfg_t;

    // pin-driving peripheral request: drive enable and value
    typedef struct packed {
        logic en;
        logic val;
    } dgp_drv_t;
endpackage

// >>> dgp_brd.sv
// board model: resolves every port pin from block drive, board drive and pull-ups
`timescale 1ns/1ns
module dgp_brd (
    input  wire logic [15:0] out,
    input  wire logic [15:0] oe_n,
    input  wire logic [15:0] ext_en,
    input  wire logic [15:0] ext_val,
    output logic      [15:0] pin
);
    // the block wins a clash; a pin nobody drives floats up to the pull-up level
    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            if (!oe_n[i])
                pin[i] = out[i];
            else if (ext_en[i])
                pin[i] = ext_val[i];
            else
                pin[i] = 1'b1;
        end
    end
endmodule // dgp_brd

// >>> dual_gpio_port_with_pin_mux_tb.sv
// testbench: register access, pin drive, peripheral overrides and pin mux of the dual port
`timescale 1ns/1ns
`define CHK(nm, got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
        end \
    end
module dual_gpio_port_with_pin_mux_tb;
    import dgp_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  port_c_in, port_c_out, port_c_oe_n, port_d_in, port_d_out, port_d_oe_n;
    dgp_drv_t    timer1_osc_output, capture_compare_unit1, capture_compare_unit2, ssp_data_out;
    dgp_drv_t    ssp_clock_out, ssp_sda_out, usart_tx_clock, usart_data_out, pwm_out_4, pwm_out_6, pwm_out_7;
    logic        timer1_osc_enable, spi_slave_mode, external_irq_0, external_irq_1, external_irq_2;
    logic        timer0_ext_clock, timer5_ext_clock, fault_input_a, fault_input_b, timer1_ext_clock;
    logic        timer1_osc_input, capture_compare_unit1_capture_in, capture_compare_unit2_capture_in, ssp_data_in, ssp_clock_in;
    logic        spi_slave_select_n, usart_rx_data;
    logic [15:0] ext_en, ext_val, pin;
    logic [31:0] rd;
    logic [1:0]  rs;
    int          miscompares, n_checks;

    dgp_top u_dgp_top (.*);
    dgp_brd u_dgp_brd (.out({port_d_out, port_c_out}), .oe_n({port_d_oe_n, port_c_oe_n}), .ext_en(ext_en),
                       .ext_val(ext_val), .pin(pin));
    assign port_c_in = pin[7:0];
    assign port_d_in = pin[15:8];

    initial aclk = 1'b0;
    always #25 aclk = ~aclk;

    // waits at least one edge for a handshake: 0 awready, 1 bvalid, 2 arready, 3 rvalid
    task automatic wait_hi(input int w);
        int   n;
        logic s;
        n = 0;
        s = 1'b0;
        while (s !== 1'b1 && n < 50)
        begin
            @(posedge aclk);
            n++;
            case (w)
                0:       s = s_axi_awready;
                1:       s = s_axi_bvalid;
                2:       s = s_axi_arready;
                default: s = s_axi_rvalid;
            endcase
        end
        if (s !== 1'b1)
        begin
            miscompares++;
            $display("[FAIL] handshake %0d expected 1 seen %b", w, s);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        wait_hi(0);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        wait_hi(1);
        r = s_axi_bresp;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        wait_hi(2);
        s_axi_arvalid <= 1'b0;
        wait_hi(3);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic wchk(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        axw(a, d, r);
        `CHK("bresp", r, DGP_RESP_OKAY)
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axr(a, d, r);
        `CHK(nm, {r, d}, {DGP_RESP_OKAY, 24'h000000, e})
    endtask

    task automatic settle;
        repeat (3) @(posedge aclk);
    endtask

    task automatic tend(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #(50 * 5000);
        miscompares++;
        print_verdict;
    end

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
        {timer1_osc_output, capture_compare_unit1, capture_compare_unit2, ssp_data_out} = '0;
        {ssp_clock_out, ssp_sda_out, usart_tx_clock, usart_data_out, pwm_out_4, pwm_out_6, pwm_out_7} = '0;
        {timer1_osc_enable, spi_slave_mode, miscompares, n_checks} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wdata, s_axi_wstrb} = {2'b11, 32'h0, 4'hf};
        ext_en = 16'h0000;
        ext_val = 16'h0000;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK("oe_n", {port_d_oe_n, port_c_oe_n}, 16'hffff)
        rchk("dir_c", DGP_C_DIR_OFF, DGP_DIR_RST);
        rchk("dir_d", DGP_D_DIR_OFF, DGP_DIR_RST);
        rchk("cfg", DGP_CFG_OFF, 8'h00);
        tend("reset");
        ext_en  <= 16'hffff;
        ext_val <= 16'h0033;
        wchk(DGP_C_LAT_OFF, 8'ha5);
        wchk(DGP_D_LAT_OFF, 8'h5a);
        wchk(DGP_C_DIR_OFF, 8'h0f);
        wchk(DGP_D_DIR_OFF, 8'hf0);
        settle;
        `CHK("oe_c", port_c_oe_n, 8'h0f)
        `CHK("out_c", port_c_out, 8'ha0)
        `CHK("out_d", {port_d_oe_n, port_d_out}, 16'hf00a)
        rchk("lat_c", DGP_C_LAT_OFF, 8'ha5);
        rchk("pin_c", DGP_C_PIN_OFF, 8'ha3);
        wchk(DGP_C_PIN_OFF, 8'hc6);
        settle;
        rchk("lat_c2", DGP_C_LAT_OFF, 8'hc6);
        rchk("pin_c2", DGP_C_PIN_OFF, 8'hc3);
        tend("latch");
        wchk(DGP_C_LAT_OFF, 8'h00);
        wchk(DGP_C_DIR_OFF, 8'h00);
        timer1_osc_output     <= 2'b11;
        capture_compare_unit1 <= 2'b11;
        capture_compare_unit2 <= 2'b11;
        ssp_data_out          <= 2'b11;
        usart_data_out        <= 2'b10;
        usart_tx_clock        <= 2'b11;
        timer1_osc_enable     <= 1'b1;
        spi_slave_mode        <= 1'b1;
        settle;
        `CHK("oe_c", port_c_oe_n, 8'h42)
        `CHK("out_c", port_c_out, 8'h05)
        `CHK("t1", {timer1_ext_clock, timer1_osc_input, spi_slave_select_n, capture_compare_unit1_capture_in}, 4'hd)
        rchk("dir_c", DGP_C_DIR_OFF, 8'h00);
        tend("override");
        usart_data_out <= 2'b00;
        pwm_out_4      <= 2'b11;
        pwm_out_6      <= 2'b11;
        pwm_out_7      <= 2'b11;
        wchk(DGP_C_DIR_OFF, 8'hff);
        wchk(DGP_D_DIR_OFF, 8'hff);
        wchk(DGP_CFG_OFF, 8'h12);
        settle;
        `CHK("oe_c", port_c_oe_n, 8'hfa)
        `CHK("oe_d", port_d_oe_n, 8'h1d)
        `CHK("out_d", port_d_out, 8'he2)
        tend("routing");
        {timer1_osc_output, capture_compare_unit1, capture_compare_unit2, ssp_data_out} <= '0;
        {usart_tx_clock, pwm_out_4, pwm_out_6, pwm_out_7, timer1_osc_enable, spi_slave_mode} <= '0;
        for (int k = 0; k < 4; k++)
        begin
            ext_val <= k[1] ? 16'h00ff : 16'hff00;
            wchk(DGP_CFG_OFF, k[0] ? 8'h0f : 8'h00);
            settle;
            `CHK("mux", {ssp_data_in, ssp_clock_in, timer0_ext_clock, timer5_ext_clock, fault_input_a}, {5{k[0] ^ k[1]}})
            `CHK("fix", {capture_compare_unit2_capture_in, fault_input_b}, {!k[0] && k[1], k[1]})
        end
        ext_val <= 16'h00a8;
        settle;
        `CHK("irq", {external_irq_2, external_irq_1, external_irq_0}, 3'b101)
        `CHK("rx", usart_rx_data, 1'b1)
        tend("mux");
        axw(8'h1c, 8'h00, rs);
        `CHK("bad_w", rs, DGP_RESP_SLVERR)
        axr(8'h1c, rd, rs);
        `CHK("bad_r", {rs, rd}, {DGP_RESP_SLVERR, 32'h0})
        tend("unmapped");
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK("oe_n", {port_d_oe_n, port_c_oe_n}, 16'hffff)
        rchk("dir_c", DGP_C_DIR_OFF, 8'hff);
        rchk("lat_d", DGP_D_LAT_OFF, 8'h5a);
        tend("warm_reset");
        print_verdict;
    end
endmodule // dual_gpio_port_with_pin_mux_tb
